// *** ofp_host_model.sv ***
// Host model: chip select, configuration loads and output commands
module ofp_host_model
  import ofp_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Host side drives
  output logic serial_select_n_o,
  output logic [OFP_NUM_LS-1:0] ls_cfg_o,
  output logic [OFP_NUM_HS-1:0] hs_cfg_o,
  output logic cfg_load_o,
  output logic [OFP_NUM_LS-1:0] ls_cmd_o,
  output logic [OFP_NUM_HS-1:0] hs_cmd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    serial_select_n_o = 1'b1;
    {ls_cfg_o, hs_cfg_o, cfg_load_o} = '0;
    {ls_cmd_o, hs_cmd_o} = '0;
  end
  // Vectors hold after the pulse, so a late sample sees the same value
  task load_cfg(input logic [7:0] ls, input logic [3:0] hs);
    @(negedge clk_i);
    {ls_cfg_o, hs_cfg_o, cfg_load_o} = {ls, hs, 1'b1};
    @(negedge clk_i);
    cfg_load_o = 1'b0;
  endtask
  // Frame: select low long enough to pass the synchroniser
  task frame();
    @(negedge clk_i);
    serial_select_n_o = 1'b0;
    repeat (4) @(negedge clk_i);
    serial_select_n_o = 1'b1;
  endtask
  task cmd(input logic [7:0] ls, input logic [3:0] hs);
    @(negedge clk_i);
    {ls_cmd_o, hs_cmd_o} = {ls, hs};
  endtask
endmodule // ofp_host_model

// *** ofp_output_fault.sv ***
// Fault handling for eight low-side and four high-side power outputs
// How it works
// - Shutdown mode: lasting over-current turns output off, fault latched
// - Retry into lasting over-current trips again, status stays set
// - Retry with fault gone runs; status clears on select rising edge
// - Limit mode: over-current held in limit until over-temperature
// - Over-current gone before over-temperature leaves output unaffected
// - Limit-select low: high side starts at peak, sustain after timer
// - Limit-select high: high side uses sustain limit from switch-on
// - High side off while hot, on again once cool, until commanded off
// - Below run supply outputs off; state kept above hold threshold
// - Supply below hold threshold reinitialises logic to defaults
// - Ground or supply loss forces every output off.
// - After reset all configuration bits act as low.
module ofp_output_fault
  import ofp_pkg::*;
#(
  parameter int FLT_CYC = OFP_FLT_CYC,
  parameter int PEAK_CYC = OFP_PEAK_CYC
)(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Serial interface select and configuration
  input wire logic serial_select_n_i,
  input wire logic [OFP_NUM_LS-1:0] lowside_shutdown_enable_config_i,
  input wire logic [OFP_NUM_HS-1:0] current_limit_mode_config_i,
  input wire logic cfg_load_i,
  // Output commands
  input wire logic [OFP_NUM_LS-1:0] ls_cmd_i,
  input wire logic [OFP_NUM_HS-1:0] hs_cmd_i,
  // Analog sensing (asynchronous)
  input wire logic [OFP_NUM_LS-1:0] ls_overcurrent_i,
  input wire logic [OFP_NUM_LS-1:0] ls_overtemp_i,
  input wire logic [OFP_NUM_HS-1:0] hs_overtemp_i,
  input wire ofp_supply_t supply_i,
  // Gate drives
  output logic [OFP_NUM_LS-1:0] ls_gate_o,
  output logic [OFP_NUM_HS-1:0] hs_gate_o,
  // Limit selection and status
  output logic [OFP_NUM_LS-1:0] lowside_limit_current_o,
  output logic [OFP_NUM_HS-1:0] highside_peak_limit_o,
  output logic [OFP_NUM_HS-1:0] highside_sustain_limit_o,
  output logic [OFP_NUM_LS-1:0] ls_status_o,
  output logic [OFP_NUM_HS-1:0] hs_status_o
);
  localparam int FW = $clog2(FLT_CYC + 1);
  localparam int PW = $clog2(PEAK_CYC + 1);
  localparam int NS = $bits(ofp_supply_t) + 3 * OFP_NUM_LS + OFP_NUM_HS + 1;

  // Counters must reach at least one count
  if (FLT_CYC < 1 || PEAK_CYC < 1)
  begin : g_bad_timer
    $error("Timer counts must be at least one");
  end

  // Two-flop synchronisers for everything from the analog side
  logic [NS-1:0] s1_r;
  logic [NS-1:0] s2_r;
  always_ff @(posedge clk_i)
  begin
    s1_r <= {supply_i, ls_overcurrent_i, ls_overtemp_i, hs_overtemp_i,
             serial_select_n_i, ls_cmd_i};
    s2_r <= s1_r;
  end

  ofp_supply_t sup;
  logic [OFP_NUM_LS-1:0] oc;
  logic [OFP_NUM_LS-1:0] lot;
  logic [OFP_NUM_HS-1:0] hot;
  logic sel_n;
  logic [OFP_NUM_LS-1:0] lcmd;
  assign {sup, oc, lot, hot, sel_n, lcmd} = s2_r;

  // Supply state: hold keeps state with outputs off, reset wipes it
  ofp_pwr_t pwr_r;
  ofp_pwr_t pwr_nxt;
  always_comb
  begin
    pwr_nxt = pwr_r;
    unique case (pwr_r)
      OFP_PWR_RESET: if (sup.above_run) pwr_nxt = OFP_PWR_RUN;
      OFP_PWR_HOLD:
        if (!sup.above_hold) pwr_nxt = OFP_PWR_RESET;
        else if (sup.above_run) pwr_nxt = OFP_PWR_RUN;
      OFP_PWR_RUN:
        if (!sup.above_hold) pwr_nxt = OFP_PWR_RESET;
        else if (!sup.above_run) pwr_nxt = OFP_PWR_HOLD;
      default: pwr_nxt = OFP_PWR_RESET;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      pwr_r <= OFP_PWR_RESET;
    else
      pwr_r <= pwr_nxt;
  end

  logic wipe;
  logic run;
  assign wipe = !rst_n_i || pwr_r == OFP_PWR_RESET;
  // Ground or supply loss overrides every command
  assign run = pwr_r == OFP_PWR_RUN && !sup.gnd_lost
               && !sup.supply_lost;

  // Configuration registers load only while logic is alive
  logic [OFP_NUM_LS-1:0] ls_sd_en_r;
  logic [OFP_NUM_HS-1:0] hs_mode_r;
  always_ff @(posedge clk_i)
  begin
    if (wipe)
    begin
      ls_sd_en_r <= OFP_LS_RST;
      hs_mode_r <= OFP_HS_RST;
    end
    else if (cfg_load_i)
    begin
      ls_sd_en_r <= lowside_shutdown_enable_config_i;
      hs_mode_r <= current_limit_mode_config_i;
    end
  end

  logic sel_d_r;
  logic sel_rise;
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      sel_d_r <= 1'b1;
    else
      sel_d_r <= sel_n;
  end
  assign sel_rise = sel_n && !sel_d_r;

  function automatic logic timer_done(input int cnt, input int lim);
    return cnt >= lim;
  endfunction

  // Low-side channels
  logic [OFP_NUM_LS-1:0] lcmd_d_r;
  logic [OFP_NUM_LS-1:0] ls_latch_r;
  logic [FW-1:0] flt_cnt_r [OFP_NUM_LS];
  logic [OFP_NUM_LS-1:0] ls_on;
  logic [OFP_NUM_LS-1:0] ls_trip;

  for (genvar i = 0; i < OFP_NUM_LS; i++)
  begin : g_ls
    logic restart;
    assign restart = lcmd[i] && !lcmd_d_r[i];
    assign ls_on[i] = run && lcmd[i] && !ls_latch_r[i];
    assign ls_trip[i] = ls_sd_en_r[i] && oc[i]
                        && timer_done(int'(flt_cnt_r[i]), FLT_CYC);

    always_ff @(posedge clk_i)
    begin
      if (wipe || restart || !ls_on[i] || !oc[i] || !ls_sd_en_r[i])
        flt_cnt_r[i] <= '0;
      else if (!timer_done(int'(flt_cnt_r[i]), FLT_CYC))
        flt_cnt_r[i] <= flt_cnt_r[i] + FW'(1);
    end

    always_ff @(posedge clk_i)
    begin
      if (wipe)
        ls_latch_r[i] <= 1'b0;
      else if (ls_on[i] && (ls_trip[i] || lot[i]))
        ls_latch_r[i] <= 1'b1;
      else if (!lcmd[i])
        ls_latch_r[i] <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
      if (wipe)
        ls_status_o[i] <= 1'b0;
      else if (ls_on[i] && (ls_trip[i] || lot[i]))
        ls_status_o[i] <= 1'b1;
      else if (sel_rise && !ls_latch_r[i] && !(oc[i] && ls_sd_en_r[i]))
        ls_status_o[i] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (wipe)
    begin
      lcmd_d_r <= '0;
      ls_gate_o <= '0;
      lowside_limit_current_o <= '0;
    end
    else
    begin
      lcmd_d_r <= lcmd;
      ls_gate_o <= ls_on & ~ls_trip & ~lot;
      // Analog limit engages on over-current while the channel is on with shutdown disabled
      lowside_limit_current_o <= ls_on & ~ls_sd_en_r & oc;
    end
  end

  // High-side channels
  logic [OFP_NUM_HS-1:0] hcmd_d_r;
  logic [PW-1:0] pk_cnt_r [OFP_NUM_HS];
  logic [OFP_NUM_HS-1:0] hs_on;
  logic [OFP_NUM_HS-1:0] hs_peak;

  for (genvar j = 0; j < OFP_NUM_HS; j++)
  begin : g_hs
    assign hs_on[j] = run && hs_cmd_i[j] && !hot[j];
    assign hs_peak[j] = !hs_mode_r[j]
                        && !timer_done(int'(pk_cnt_r[j]), PEAK_CYC);

    always_ff @(posedge clk_i)
    begin
      if (wipe || !hs_on[j] || (hs_cmd_i[j] && !hcmd_d_r[j]))
        pk_cnt_r[j] <= '0;
      else if (!timer_done(int'(pk_cnt_r[j]), PEAK_CYC))
        pk_cnt_r[j] <= pk_cnt_r[j] + PW'(1);
    end

    always_ff @(posedge clk_i)
    begin
      if (wipe)
        hs_status_o[j] <= 1'b0;
      else if (run && hs_cmd_i[j] && hot[j])
        hs_status_o[j] <= 1'b1;
      else if (sel_rise && !hot[j])
        hs_status_o[j] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (wipe)
    begin
      hcmd_d_r <= '0;
      hs_gate_o <= '0;
      highside_peak_limit_o <= '0;
      highside_sustain_limit_o <= '0;
    end
    else
    begin
      hcmd_d_r <= hs_cmd_i;
      hs_gate_o <= hs_on;
      highside_peak_limit_o <= hs_on & hs_peak;
      highside_sustain_limit_o <= hs_on & ~hs_peak;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Overloaded shutdown channel, already on for a cycle, so no restart
  sequence s_ls_oc_held;
    ls_sd_en_r[1] && ls_on[1] && oc[1] && lcmd_d_r[1];
  endsequence

  // Switched-on high side whose peak time has run out
  sequence s_hs_peak_over;
    hs_on[0] && timer_done(int'(pk_cnt_r[0]), PEAK_CYC);
  endsequence

  // Channel 1 watched in shutdown mode, channel 0 in limit mode
  ls_trip_off_a: assert property (
    ls_trip[1] && ls_on[1] |=> !ls_gate_o[1] && ls_status_o[1])
    else $error("Low side not off after fault timeout");
  ls_latch_hold_a: assert property (
    ls_latch_r[1] && lcmd[1] |=> !ls_gate_o[1])
    else $error("Latched low side turned on without retry");
  ls_timer_cnt_a: assert property (
    s_ls_oc_held [*2] |-> flt_cnt_r[1] != '0)
    else $error("Fault timer not counting");
  ls_clear_a: assert property (
    sel_rise && !ls_latch_r[1] && !oc[1] && !lot[1]
      |=> !ls_status_o[1])
    else $error("Status not cleared on select rise");
  ls_limit_a: assert property (
    !ls_sd_en_r[0] && oc[0] && !lot[0]
      |-> !ls_latch_r[0] || $past(lot[0]) || $past(ls_latch_r[0]))
    else $error("Low side shut down without over-temperature");
  ls_noflt_a: assert property (
    run && lcmd[0] && !oc[0] && !lot[0] && !ls_latch_r[0]
      |=> ls_gate_o[0])
    else $error("Low side not driven after fault cleared");
  ls_limit_on_a: assert property (
    !ls_sd_en_r[0] && ls_on[0] && oc[0] && !lot[0]
      |=> ls_gate_o[0] && lowside_limit_current_o[0])
    else $error("Limited low side not kept on in limit");
  hs_peak_a: assert property (
    hs_on[0] && !hs_mode_r[0] && pk_cnt_r[0] == '0
      |=> highside_peak_limit_o[0])
    else $error("Peak limit missing at switch-on");
  hs_sus_a: assert property (
    hs_mode_r[1] && hs_on[1] |=> !highside_peak_limit_o[1])
    else $error("Peak limit used in sustain-only mode");
  hs_peak_end_a: assert property (
    s_hs_peak_over |=> !highside_peak_limit_o[0]
      && highside_sustain_limit_o[0])
    else $error("Peak limit kept after peak time");
  hs_stat_a: assert property (
    run && hs_cmd_i[0] && hot[0] |=> hs_status_o[0] && !hs_gate_o[0])
    else $error("Hot high side not reported");
  hs_therm_a: assert property (
    hot[0] |=> !hs_gate_o[0])
    else $error("High side on while hot");
  pwr_off_a: assert property (
    !run |=> ls_gate_o == '0 && hs_gate_o == '0)
    else $error("Outputs on without valid supply");
  pwr_wipe_a: assert property (
    pwr_r == OFP_PWR_RESET |=> ls_sd_en_r == '0 && hs_mode_r == '0)
    else $error("Configuration kept through supply loss");
endmodule : ofp_output_fault

// *** ofp_pkg.sv ***
// Shared constants and carrier types for the output fault protection block
package ofp_pkg;
  localparam int OFP_NUM_LS = 8;
  localparam int OFP_NUM_HS = 4;
  localparam int OFP_CLK_MHZ = 40;
  // Fault filter and peak-limit times in microseconds
  localparam int OFP_FLT_US = 100;
  localparam int OFP_PEAK_US = 1000;
  localparam int OFP_FLT_CYC = OFP_FLT_US * OFP_CLK_MHZ;
  localparam int OFP_PEAK_CYC = OFP_PEAK_US * OFP_CLK_MHZ;
  localparam logic [OFP_NUM_LS-1:0] OFP_LS_RST = 8'h00;
  localparam logic [OFP_NUM_HS-1:0] OFP_HS_RST = 4'h0;

  // Supply condition seen by the comparators
  typedef struct packed {
    logic above_run;   // Supply above the run threshold
    logic above_hold;  // Supply above the state-retention threshold
    logic gnd_lost;    // Ground connection lost
    logic supply_lost; // Supply connection lost
  } ofp_supply_t;

  typedef enum logic [1:0] {
    OFP_PWR_RESET = 2'b00,
    OFP_PWR_HOLD  = 2'b01,
    OFP_PWR_RUN   = 2'b10
  } ofp_pwr_t;
endpackage : ofp_pkg

// *** testbench.sv ***
// Directed bench for the output fault protection block
module testbench;
  import ofp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel_n, ld;
  logic [7:0] ls_cfg, ls_cmd, oc = '0, ot = '0;
  logic [7:0] ls_gate, ls_lim, ls_st;
  logic [3:0] hs_cfg, hs_cmd, hot = '0;
  logic [3:0] hs_gate, pk, sus, hs_st;
  ofp_supply_t sup = '0;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  ofp_host_model i_host (.clk_i(clk), .serial_select_n_o(sel_n),
    .ls_cfg_o(ls_cfg), .hs_cfg_o(hs_cfg), .cfg_load_o(ld),
    .ls_cmd_o(ls_cmd), .hs_cmd_o(hs_cmd));
  ofp_output_fault #(.FLT_CYC(4), .PEAK_CYC(8)) i_dut (.clk_i(clk),
    .rst_n_i(rst_n), .serial_select_n_i(sel_n),
    .lowside_shutdown_enable_config_i(ls_cfg),
    .current_limit_mode_config_i(hs_cfg), .cfg_load_i(ld),
    .ls_cmd_i(ls_cmd), .hs_cmd_i(hs_cmd), .ls_overcurrent_i(oc),
    .ls_overtemp_i(ot), .hs_overtemp_i(hot), .supply_i(sup),
    .ls_gate_o(ls_gate), .hs_gate_o(hs_gate),
    .lowside_limit_current_o(ls_lim), .highside_peak_limit_o(pk),
    .highside_sustain_limit_o(sus), .ls_status_o(ls_st),
    .hs_status_o(hs_st));
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task close_out();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      close_out();
    end
  end
  initial
  begin
    w(4);
    chk("rst_out", {ls_gate, hs_gate, hs_st}, 16'h0000);
    rst_n = 1'b1;
    sup = 4'b1100;
    w(6);
    i_host.cmd(8'h01, 4'h0);
    // Only one channel of a ground pair is ever overloaded at once
    oc = 8'h01;
    w(12);
    chk("ls_limit", {ls_gate, ls_lim}, 16'h0101);
    chk("ls_nostat", ls_st, 16'h0000);
    oc = '0;
    w(8);
    chk("ls_free", {ls_gate, ls_lim}, 16'h0100);
    ot = 8'h01;
    w(8);
    chk("ls_hot_off", ls_gate, 16'h0000);
    chk("ls_hot_st", ls_st, 16'h0001);
    ot = '0;
    i_host.load_cfg(8'h02, 4'h2);
    i_host.cmd(8'h02, 4'h0);
    w(6);
    oc = 8'h02;
    w(16);
    chk("ls_trip", {ls_gate, ls_st}, 16'h0003);
    i_host.cmd(8'h00, 4'h0);
    w(4);
    i_host.cmd(8'h02, 4'h0);
    w(16);
    chk("ls_retry_bad", {ls_gate, ls_st}, 16'h0003);
    i_host.cmd(8'h00, 4'h0);
    oc = '0;
    w(4);
    i_host.cmd(8'h02, 4'h0);
    w(10);
    chk("ls_retry_ok", ls_gate, 16'h0002);
    i_host.frame();
    w(4);
    chk("ls_st_clr", ls_st, 16'h0000);
    i_host.cmd(8'h02, 4'h3);
    w(3);
    chk("hs_peak", {pk, sus}, 16'h0012);
    w(20);
    chk("hs_sus", {pk, sus}, 16'h0003);
    hot = 4'h1;
    w(8);
    chk("hs_hot", hs_gate, 16'h0002);
    chk("hs_st", hs_st, 16'h0001);
    hot = '0;
    w(8);
    chk("hs_cool", hs_gate, 16'h0003);
    sup = 4'b0100;
    w(8);
    chk("uv_off", {ls_gate, hs_gate}, 16'h0000);
    sup = 4'b1100;
    w(8);
    chk("uv_back", {ls_gate, hs_gate}, 16'h0023);
    sup = 4'b0000;
    w(8);
    sup = 4'b1100;
    w(8);
    oc = 8'h02;
    w(16);
    chk("reinit", {ls_gate, ls_lim}, 16'h0202);
    oc = '0;
    sup = 4'b1110;
    w(8);
    chk("gnd_lost", {ls_gate, hs_gate}, 16'h0000);
    sup = 4'b1101;
    w(8);
    chk("sup_lost", {ls_gate, hs_gate}, 16'h0000);
    sup = 4'b1100;
    i_host.cmd(8'h00, 4'h0);
    w(8);
    chk("cmd_off", {ls_gate, hs_gate}, 16'h0000);
    close_out();
  end
endmodule // testbench
